//--- common/hvc_lnk_if.sv
// Point-to-point link between the host end and the device end.
// Assumes both ends share one clock; receivers always accept (credits).
`timescale 1ns/1ps
interface hvc_lnk_if;
  import hvc_pkg::*;
  logic h2d_valid;
  hvc_cmd_t h2d_cmd;
  logic h2d_isoc;
  logic h2d_ppw;
  logic [HVC_TAG_W-1:0] h2d_tag;
  logic d2h_valid;
  hvc_cmd_t d2h_cmd;
  logic d2h_isoc;
  logic d2h_ppw;
  logic [HVC_TAG_W-1:0] d2h_tag;

  modport dev (
    input h2d_valid, h2d_cmd, h2d_isoc, h2d_ppw, h2d_tag,
    output d2h_valid, d2h_cmd, d2h_isoc, d2h_ppw, d2h_tag
  );
  modport host (
    output h2d_valid, h2d_cmd, h2d_isoc, h2d_ppw, h2d_tag,
    input d2h_valid, d2h_cmd, d2h_isoc, d2h_ppw, d2h_tag
  );
endinterface : hvc_lnk_if

//--- common/hvc_pkg.sv
// Shared definitions for the virtual-channel flow-control link ends.
// Assumes both ends run on the single system clock.
package hvc_pkg;

  // ----------------------------------------
  // Link packet fields
  // ----------------------------------------
  localparam int HVC_TAG_W = 8;
  localparam int HVC_NVC = 6;
  localparam int HVC_NTAG = 16;
  localparam int HVC_TBL_W = 4;

  typedef enum logic [3:0] {
    HVC_NOP = 4'h0,
    HVC_WR_P = 4'h1,
    HVC_WR_NP = 4'h2,
    HVC_RD = 4'h3,
    HVC_RD_REPLY = 4'h4,
    HVC_TGT_DONE = 4'h5,
    HVC_BCAST = 4'h6,
    HVC_ATOMIC = 4'h7,
    HVC_FENCE = 4'h8,
    HVC_FLUSH = 4'h9
  } hvc_cmd_t;

  // ----------------------------------------
  // Channel classes, index layout, reset values
  // ----------------------------------------
  localparam logic [1:0] HVC_CLS_P = 2'h0;
  localparam logic [1:0] HVC_CLS_NP = 2'h1;
  localparam logic [1:0] HVC_CLS_RSP = 2'h2;
  localparam logic [2:0] HVC_ISOC_BASE = 3'h3;
  localparam logic [HVC_NVC-1:0] HVC_CRED_RST = 6'h3F;
  localparam logic [3:0] HVC_FAIR_LIMIT = 4'h4;

  function automatic logic [1:0] hvc_cls(input hvc_cmd_t c);
    case (c)
      HVC_WR_P, HVC_BCAST, HVC_FENCE: return HVC_CLS_P;
      HVC_RD_REPLY, HVC_TGT_DONE: return HVC_CLS_RSP;
      default: return HVC_CLS_NP;
    endcase
  endfunction : hvc_cls

  // Broadcast and atomic never ride the high-priority channels
  function automatic logic [2:0] hvc_vc(input hvc_cmd_t c,
                                        input logic isoc,
                                        input logic mode);
    logic hi;
    hi = mode && isoc && c != HVC_BCAST && c != HVC_ATOMIC && c != HVC_NOP;
    return hi ? 3'(hvc_cls(c)) + HVC_ISOC_BASE : 3'(hvc_cls(c));
  endfunction : hvc_vc

endpackage : hvc_pkg

//--- logic/hvc_dev_end.sv
// Device end of the link: six credited virtual channels, isochronous
// mode latched at warm reset, strict priority and fairness counting.
// Assumes the host end shares the clock and resets with this end.
`timescale 1ns/1ps
module hvc_dev_end import hvc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cold_resetn,
  // Configuration
  input wire logic i_isoc_sw_en,
  input wire logic i_pw_bypass,
  // Link
  hvc_lnk_if.dev lnk,
  // Received packets
  output logic o_rx_valid,
  output hvc_cmd_t o_rx_cmd,
  output logic o_rx_isoc,
  output logic o_rx_ppw,
  output logic [HVC_TAG_W-1:0] o_rx_tag,
  input wire logic i_rx_ready,
  // Packets to send
  input wire logic i_tx_valid,
  input wire hvc_cmd_t i_tx_cmd,
  input wire logic i_tx_isoc,
  input wire logic i_tx_ppw,
  input wire logic [HVC_TAG_W-1:0] i_tx_tag,
  output logic o_tx_ready,
  // Status
  output logic o_isoc_mode
);

  logic sw_en_r;
  logic [HVC_NVC-1:0] ret_pend;
  logic [HVC_NVC-1:0] ret_ack;
  logic [HVC_NVC-1:0] cred_r;
  logic np_isoc_r [HVC_NTAG];
  logic hold_v_r;
  hvc_cmd_t hold_cmd_r;
  logic hold_isoc_r;
  logic hold_ppw_r;
  logic [HVC_TAG_W-1:0] hold_tag_r;
  logic [2:0] hold_vc_r;
  logic [3:0] fair_cnt_r;
  logic hold_hi;
  logic hold_ok;
  logic nop_any;
  logic nop_hi;
  logic fair_due;
  logic send_hold;
  logic send_nop;
  logic tx_acc;
  logic hold_full_nxt;
  logic tx_isoc_eff;
  logic rx_nop;
  logic rx_nop_hi;
  logic rx_take_np;

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  // Software enable only becomes the live mode across a warm reset,
  // so the channel split never changes under traffic.
  always_ff @(posedge i_clk_sys) begin
    if (!i_cold_resetn) begin
      sw_en_r <= 1'b0;
    end else begin
      sw_en_r <= i_isoc_sw_en;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_cold_resetn) begin
      o_isoc_mode <= 1'b0;
    end else if (!i_resetn) begin
      o_isoc_mode <= sw_en_r;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  hvc_rx_vcs u_rx (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_isoc_mode(o_isoc_mode),
    .i_pw_bypass(i_pw_bypass),
    .i_lnk_valid(lnk.h2d_valid),
    .i_lnk_cmd(lnk.h2d_cmd),
    .i_lnk_isoc(lnk.h2d_isoc),
    .i_lnk_ppw(lnk.h2d_ppw),
    .i_lnk_tag(lnk.h2d_tag),
    .o_valid(o_rx_valid),
    .o_cmd(o_rx_cmd),
    .o_isoc(o_rx_isoc),
    .o_ppw(o_rx_ppw),
    .o_tag(o_rx_tag),
    .i_ready(i_rx_ready),
    .o_ret_pend(ret_pend),
    .i_ret_ack(ret_ack)
  );

  // Flag of each accepted nonposted request, kept for its response
  assign rx_take_np = o_rx_valid && i_rx_ready &&
                      hvc_cls(o_rx_cmd) == HVC_CLS_NP;

  for (genvar t = 0; t < HVC_NTAG; t++) begin : g_np
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        np_isoc_r[t] <= 1'b0;
      end else if (rx_take_np &&
                   o_rx_tag[HVC_TBL_W-1:0] == HVC_TBL_W'(t)) begin
        np_isoc_r[t] <= o_rx_isoc;
      end
    end
  end

  // ----------------------------------------
  // Credits from the far end
  // ----------------------------------------
  assign rx_nop = lnk.h2d_valid && lnk.h2d_cmd == HVC_NOP;
  assign rx_nop_hi = lnk.h2d_isoc && o_isoc_mode;

  // A returned credit wins over a send in the same cycle
  for (genvar v = 0; v < HVC_NVC; v++) begin : g_cred
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        cred_r[v] <= HVC_CRED_RST[v];
      end else if (rx_nop && (rx_nop_hi == (v >= 3)) &&
                   lnk.h2d_tag[v % 3]) begin
        cred_r[v] <= 1'b1;
      end else if (send_hold && hold_vc_r == 3'(v)) begin
        cred_r[v] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit arbitration
  // ----------------------------------------
  assign tx_acc = i_tx_valid && o_tx_ready;
  assign tx_isoc_eff = i_tx_isoc || (hvc_cls(i_tx_cmd) == HVC_CLS_RSP &&
                       np_isoc_r[i_tx_tag[HVC_TBL_W-1:0]]);
  assign hold_hi = hold_vc_r >= HVC_ISOC_BASE;
  assign hold_ok = hold_v_r && cred_r[hold_vc_r];
  assign nop_hi = o_isoc_mode && (|ret_pend[5:3]);
  assign nop_any = |ret_pend;
  assign fair_due = fair_cnt_r == HVC_FAIR_LIMIT;
  // High class bypasses fairness; ordinary yields to credits when due
  assign send_hold = hold_ok && (hold_hi || !(nop_any && fair_due));
  assign send_nop = nop_any && !send_hold;
  assign ret_ack = !send_nop ? '0 :
                   nop_hi ? {ret_pend[5:3], 3'h0} : {3'h0, ret_pend[2:0]};
  assign hold_full_nxt = (hold_v_r && !send_hold) || tx_acc;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hold_v_r <= 1'b0;
      o_tx_ready <= 1'b0;
    end else begin
      hold_v_r <= hold_full_nxt;
      o_tx_ready <= !hold_full_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hold_cmd_r <= HVC_NOP;
      hold_isoc_r <= 1'b0;
      hold_ppw_r <= 1'b0;
      hold_tag_r <= '0;
      hold_vc_r <= 3'h0;
    end else if (tx_acc) begin
      hold_cmd_r <= i_tx_cmd;
      hold_isoc_r <= tx_isoc_eff;
      hold_ppw_r <= i_tx_ppw;
      hold_tag_r <= i_tx_tag;
      hold_vc_r <= hvc_vc(i_tx_cmd, tx_isoc_eff, o_isoc_mode);
    end
  end

  // Only ordinary sends are counted
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      fair_cnt_r <= 4'h0;
    end else if (send_nop) begin
      fair_cnt_r <= 4'h0;
    end else if (send_hold && !hold_hi && !fair_due) begin
      fair_cnt_r <= fair_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Link output
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      lnk.d2h_valid <= 1'b0;
      lnk.d2h_cmd <= HVC_NOP;
      lnk.d2h_isoc <= 1'b0;
      lnk.d2h_ppw <= 1'b0;
      lnk.d2h_tag <= '0;
    end else begin
      lnk.d2h_valid <= send_hold || send_nop;
      lnk.d2h_cmd <= send_hold ? hold_cmd_r : HVC_NOP;
      lnk.d2h_isoc <= send_hold ? hold_isoc_r : nop_hi;
      lnk.d2h_ppw <= send_hold && hold_ppw_r;
      lnk.d2h_tag <= send_hold ? hold_tag_r :
                     {5'h00, nop_hi ? ret_pend[5:3] : ret_pend[2:0]};
    end
  end

endmodule : hvc_dev_end

//--- logic/hvc_host_end.sv
// Host end of the link: credited send path with the optional mode that
// flags every downstream response as allowed to pass posted writes.
// Assumes the device end shares the clock and resets with this end.
`timescale 1ns/1ps
module hvc_host_end import hvc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cold_resetn,
  // Configuration
  input wire logic i_isoc_sw_en,
  input wire logic i_force_ppw,
  // Link
  hvc_lnk_if.host lnk,
  // Received packets
  output logic o_rx_valid,
  output hvc_cmd_t o_rx_cmd,
  output logic o_rx_isoc,
  output logic o_rx_ppw,
  output logic [HVC_TAG_W-1:0] o_rx_tag,
  input wire logic i_rx_ready,
  // Packets to send
  input wire logic i_tx_valid,
  input wire hvc_cmd_t i_tx_cmd,
  input wire logic i_tx_isoc,
  input wire logic i_tx_ppw,
  input wire logic [HVC_TAG_W-1:0] i_tx_tag,
  output logic o_tx_ready,
  // Status
  output logic o_isoc_mode
);

  logic sw_en_r;
  logic [HVC_NVC-1:0] ret_pend;
  logic [HVC_NVC-1:0] ret_ack;
  logic [HVC_NVC-1:0] cred_r;
  logic hold_v_r;
  hvc_cmd_t hold_cmd_r;
  logic hold_isoc_r;
  logic hold_ppw_r;
  logic [HVC_TAG_W-1:0] hold_tag_r;
  logic [2:0] hold_vc_r;
  logic send_hold;
  logic send_nop;
  logic nop_hi;
  logic tx_acc;
  logic hold_full_nxt;
  logic rx_nop;

  always_ff @(posedge i_clk_sys) begin
    if (!i_cold_resetn) begin
      sw_en_r <= 1'b0;
      o_isoc_mode <= 1'b0;
    end else begin
      sw_en_r <= i_isoc_sw_en;
      if (!i_resetn) begin
        o_isoc_mode <= sw_en_r;
      end
    end
  end

  hvc_rx_vcs u_rx (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_isoc_mode(o_isoc_mode),
    .i_pw_bypass(1'b0),
    .i_lnk_valid(lnk.d2h_valid),
    .i_lnk_cmd(lnk.d2h_cmd),
    .i_lnk_isoc(lnk.d2h_isoc),
    .i_lnk_ppw(lnk.d2h_ppw),
    .i_lnk_tag(lnk.d2h_tag),
    .o_valid(o_rx_valid),
    .o_cmd(o_rx_cmd),
    .o_isoc(o_rx_isoc),
    .o_ppw(o_rx_ppw),
    .o_tag(o_rx_tag),
    .i_ready(i_rx_ready),
    .o_ret_pend(ret_pend),
    .i_ret_ack(ret_ack)
  );

  assign rx_nop = lnk.d2h_valid && lnk.d2h_cmd == HVC_NOP;
  for (genvar v = 0; v < HVC_NVC; v++) begin : g_cred
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        cred_r[v] <= HVC_CRED_RST[v];
      end else if (rx_nop && ((lnk.d2h_isoc && o_isoc_mode) == (v >= 3)) &&
                   lnk.d2h_tag[v % 3]) begin
        cred_r[v] <= 1'b1;
      end else if (send_hold && hold_vc_r == 3'(v)) begin
        cred_r[v] <= 1'b0;
      end
    end
  end

  // Credit returns go first; the host has no fairness duty here
  assign nop_hi = o_isoc_mode && (|ret_pend[5:3]);
  assign send_nop = |ret_pend;
  assign send_hold = !send_nop && hold_v_r && cred_r[hold_vc_r];
  assign ret_ack = !send_nop ? '0 :
                   nop_hi ? {ret_pend[5:3], 3'h0} : {3'h0, ret_pend[2:0]};
  assign tx_acc = i_tx_valid && o_tx_ready;
  assign hold_full_nxt = (hold_v_r && !send_hold) || tx_acc;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hold_v_r <= 1'b0;
      o_tx_ready <= 1'b0;
      hold_cmd_r <= HVC_NOP;
      hold_isoc_r <= 1'b0;
      hold_ppw_r <= 1'b0;
      hold_tag_r <= '0;
      hold_vc_r <= 3'h0;
    end else begin
      hold_v_r <= hold_full_nxt;
      o_tx_ready <= !hold_full_nxt;
      if (tx_acc) begin
        hold_cmd_r <= i_tx_cmd;
        hold_isoc_r <= i_tx_isoc;
        hold_ppw_r <= i_tx_ppw ||
                      (i_force_ppw && hvc_cls(i_tx_cmd) == HVC_CLS_RSP);
        hold_tag_r <= i_tx_tag;
        hold_vc_r <= hvc_vc(i_tx_cmd, i_tx_isoc, o_isoc_mode);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      lnk.h2d_valid <= 1'b0;
      lnk.h2d_cmd <= HVC_NOP;
      lnk.h2d_isoc <= 1'b0;
      lnk.h2d_ppw <= 1'b0;
      lnk.h2d_tag <= '0;
    end else begin
      lnk.h2d_valid <= send_hold || send_nop;
      lnk.h2d_cmd <= send_hold ? hold_cmd_r : HVC_NOP;
      lnk.h2d_isoc <= send_hold ? hold_isoc_r : nop_hi;
      lnk.h2d_ppw <= send_hold && hold_ppw_r;
      lnk.h2d_tag <= send_hold ? hold_tag_r :
                     {5'h00, nop_hi ? ret_pend[5:3] : ret_pend[2:0]};
    end
  end

endmodule : hvc_host_end

//--- logic/hvc_rx_vcs.sv
// Receive side: one buffer slot per virtual channel, strict-priority
// delivery and credit-return bookkeeping.
// Assumes the sender never overruns a slot (it holds one credit each).
`timescale 1ns/1ps
module hvc_rx_vcs import hvc_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Mode
  input wire logic i_isoc_mode,
  input wire logic i_pw_bypass,
  // From link
  input wire logic i_lnk_valid,
  input wire hvc_cmd_t i_lnk_cmd,
  input wire logic i_lnk_isoc,
  input wire logic i_lnk_ppw,
  input wire logic [HVC_TAG_W-1:0] i_lnk_tag,
  // To user
  output logic o_valid,
  output hvc_cmd_t o_cmd,
  output logic o_isoc,
  output logic o_ppw,
  output logic [HVC_TAG_W-1:0] o_tag,
  input wire logic i_ready,
  // Credit return
  output logic [HVC_NVC-1:0] o_ret_pend,
  input wire logic [HVC_NVC-1:0] i_ret_ack
);

  logic full_r [HVC_NVC];
  logic ret_r [HVC_NVC];
  hvc_cmd_t cmd_r [HVC_NVC];
  logic isoc_r [HVC_NVC];
  logic ppw_r [HVC_NVC];
  logic [HVC_TAG_W-1:0] tag_r [HVC_NVC];
  logic [2:0] in_vc;
  logic arrive;
  logic [2:0] pick;
  logic pick_v;
  logic load;

  assign in_vc = hvc_vc(i_lnk_cmd, i_lnk_isoc, i_isoc_mode);
  assign arrive = i_lnk_valid && i_lnk_cmd != HVC_NOP;
  assign load = pick_v && (!o_valid || i_ready);

  // ----------------------------------------
  // Pick: high group overrides, posted ahead unless bypass
  // ----------------------------------------
  always_comb begin
    pick_v = 1'b0;
    pick = 3'h0;
    for (int g = 0; g < 2; g++) begin
      if (full_r[3*g + int'(HVC_CLS_NP)]) begin
        pick_v = 1'b1;
        pick = 3'(3*g + int'(HVC_CLS_NP));
      end
      if (full_r[3*g + int'(HVC_CLS_RSP)]) begin
        pick_v = 1'b1;
        pick = 3'(3*g + int'(HVC_CLS_RSP));
      end
      if (full_r[3*g + int'(HVC_CLS_P)]) begin
        pick_v = 1'b1;
        pick = 3'(3*g + int'(HVC_CLS_P));
      end
      if (i_pw_bypass && full_r[3*g + int'(HVC_CLS_RSP)] &&
          ppw_r[3*g + int'(HVC_CLS_RSP)]) begin
        pick = 3'(3*g + int'(HVC_CLS_RSP));
      end
    end
  end

  // ----------------------------------------
  // Slots
  // ----------------------------------------
  for (genvar i = 0; i < HVC_NVC; i++) begin : g_slot
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        full_r[i] <= 1'b0;
      end else if (arrive && in_vc == 3'(i)) begin
        full_r[i] <= 1'b1;
      end else if (load && pick == 3'(i)) begin
        full_r[i] <= 1'b0;
      end
    end

    // Freeing a slot beats an ack in the same cycle
    always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
        ret_r[i] <= 1'b0;
      end else if (load && pick == 3'(i)) begin
        ret_r[i] <= 1'b1;
      end else if (i_ret_ack[i]) begin
        ret_r[i] <= 1'b0;
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (arrive && in_vc == 3'(i)) begin
        cmd_r[i] <= i_lnk_cmd;
        isoc_r[i] <= i_lnk_isoc;
        ppw_r[i] <= i_lnk_ppw;
        tag_r[i] <= i_lnk_tag;
      end
    end

    assign o_ret_pend[i] = ret_r[i];
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
    end else if (load) begin
      o_valid <= 1'b1;
    end else if (i_ready) begin
      o_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_cmd <= HVC_NOP;
      o_isoc <= 1'b0;
      o_ppw <= 1'b0;
      o_tag <= '0;
    end else if (load) begin
      o_cmd <= cmd_r[pick];
      o_isoc <= isoc_r[pick];
      o_ppw <= ppw_r[pick];
      o_tag <= tag_r[pick];
    end
  end

endmodule : hvc_rx_vcs

//--- sim/hvc_lnk_assertions.sv
// Checker for the link between the host end and the device end.
// Assumes one clock, warm reset active low, both ends reset together.
`timescale 1ns/1ps
module hvc_lnk_chk import hvc_pkg::*; (
  // Clock, reset and mode
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_isoc_mode,
  // Link
  input wire logic h2d_valid,
  input wire hvc_cmd_t h2d_cmd,
  input wire logic h2d_isoc,
  input wire logic [HVC_TAG_W-1:0] h2d_tag,
  input wire logic d2h_valid,
  input wire hvc_cmd_t d2h_cmd,
  input wire logic d2h_isoc,
  input wire logic [HVC_TAG_W-1:0] d2h_tag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // ----------------------------------------
  // Flag of the last nonposted request per tag
  // ----------------------------------------
  logic [15:0] flg_r;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      flg_r <= 16'h0000;
    end else if (h2d_valid &&
        h2d_cmd inside {HVC_RD, HVC_WR_NP, HVC_ATOMIC, HVC_FLUSH}) begin
      flg_r[h2d_tag[3:0]] <= h2d_isoc;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_rst_idle_h2d: assert property (!$past(i_resetn) |-> !h2d_valid)
    else $error("host link valid right after reset");
  a_rst_idle_d2h: assert property (!$past(i_resetn) |-> !d2h_valid)
    else $error("device link valid right after reset");
  a_nop_flag_h2d: assert property (!i_isoc_mode && h2d_valid &&
    h2d_cmd == HVC_NOP |-> !h2d_isoc)
    else $error("host credit packet flagged in normal mode");
  a_nop_flag_d2h: assert property (!i_isoc_mode && d2h_valid &&
    d2h_cmd == HVC_NOP |-> !d2h_isoc)
    else $error("device credit packet flagged in normal mode");
  a_mode_hold: assert property ($past(i_resetn) |-> $stable(i_isoc_mode))
    else $error("isochronous mode changed outside reset");
  a_rsp_flag_kept: assert property (d2h_valid &&
    d2h_cmd inside {HVC_RD_REPLY, HVC_TGT_DONE} && flg_r[d2h_tag[3:0]]
    |-> d2h_isoc)
    else $error("reply to flagged request sent unflagged");
  a_cred_ret_dev: assert property (h2d_valid && h2d_cmd != HVC_NOP
    |-> ##[1:200] (d2h_valid && d2h_cmd == HVC_NOP))
    else $error("device returned no credit");
  a_cred_ret_host: assert property (d2h_valid && d2h_cmd != HVC_NOP
    |-> ##[1:200] (h2d_valid && h2d_cmd == HVC_NOP))
    else $error("host returned no credit");
endmodule : hvc_lnk_chk

//--- sim/tb_top.sv
// Testbench joining the host end and the device end over one link.
// Assumes a 250 MHz clock; index 0 is the host end, 1 the device end.
`timescale 1ns/1ps
module tb_top import hvc_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cold = 1'b0;
  logic sw_en = 1'b0;
  logic byp = 1'b0;
  logic fppw = 1'b0;
  logic [1:0] rxv, rxi, rxp, rdy, txv, txi, txp, txr, mode;
  hvc_cmd_t rxc[2];
  hvc_cmd_t txc[2];
  logic [7:0] rxt[2];
  logic [7:0] txt[2];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  hvc_lnk_if lnk ();
  hvc_host_end hvc_host_end_i (.i_clk_sys(clk), .i_resetn(rstn),
    .i_cold_resetn(cold), .i_isoc_sw_en(sw_en), .i_force_ppw(fppw),
    .lnk(lnk.host), .o_rx_valid(rxv[0]), .o_rx_cmd(rxc[0]),
    .o_rx_isoc(rxi[0]), .o_rx_ppw(rxp[0]), .o_rx_tag(rxt[0]),
    .i_rx_ready(rdy[0]), .i_tx_valid(txv[0]), .i_tx_cmd(txc[0]),
    .i_tx_isoc(txi[0]), .i_tx_ppw(txp[0]), .i_tx_tag(txt[0]),
    .o_tx_ready(txr[0]), .o_isoc_mode(mode[0]));
  hvc_dev_end hvc_dev_end_i (.i_clk_sys(clk), .i_resetn(rstn),
    .i_cold_resetn(cold), .i_isoc_sw_en(sw_en), .i_pw_bypass(byp),
    .lnk(lnk.dev), .o_rx_valid(rxv[1]), .o_rx_cmd(rxc[1]),
    .o_rx_isoc(rxi[1]), .o_rx_ppw(rxp[1]), .o_rx_tag(rxt[1]),
    .i_rx_ready(rdy[1]), .i_tx_valid(txv[1]), .i_tx_cmd(txc[1]),
    .i_tx_isoc(txi[1]), .i_tx_ppw(txp[1]), .i_tx_tag(txt[1]),
    .o_tx_ready(txr[1]), .o_isoc_mode(mode[1]));
  hvc_lnk_chk hvc_lnk_chk_i (.i_clk_sys(clk), .i_resetn(rstn),
    .i_isoc_mode(mode[1]), .h2d_valid(lnk.h2d_valid),
    .h2d_cmd(lnk.h2d_cmd), .h2d_isoc(lnk.h2d_isoc), .h2d_tag(lnk.h2d_tag),
    .d2h_valid(lnk.d2h_valid), .d2h_cmd(lnk.d2h_cmd),
    .d2h_isoc(lnk.d2h_isoc), .d2h_tag(lnk.d2h_tag));

  always #2 clk = ~clk;

  // Run is a few hundred cycles at most
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // Bounded wait on ready; a stuck hold shows as a mismatch
  task automatic snd(int e, hvc_cmd_t c, logic i, logic p, logic [7:0] t);
    int k = 0;
    @(negedge clk);
    while (txr[e] !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("tx_ready", {15'h0000, txr[e]}, 16'h0001);
    @(posedge clk);
    txv[e] <= 1'b1;
    txc[e] <= c;
    txi[e] <= i;
    txp[e] <= p;
    txt[e] <= t;
    @(posedge clk);
    txv[e] <= 1'b0;
  endtask : snd

  task automatic rcv(int e, hvc_cmd_t c, logic i, logic p, logic [7:0] t);
    int k = 0;
    @(negedge clk);
    while (rxv[e] !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("rx_pkt", {1'b0, rxv[e], rxc[e], rxi[e], rxp[e], rxt[e]},
        {2'h1, c, i, p, t});
    @(posedge clk);
  endtask : rcv

  task automatic xf(int e, hvc_cmd_t c, logic i, logic p, logic [7:0] t,
                    logic ei);
    snd(e, c, i, p, t);
    rcv(1 - e, c, ei, p, t);
  endtask : xf

  task automatic rst(logic c);
    @(posedge clk);
    rstn <= 1'b0;
    cold <= ~c;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cold <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : rst

  // Every command both ways, flags must arrive untouched
  task automatic sweep();
    for (int k = 1; k < 10; k++) begin
      xf(0, hvc_cmd_t'(k), k[0], k[1], 8'(k), k[0]);
      xf(1, hvc_cmd_t'(k), ~k[0], k[1], 8'(k + 16), ~k[0]);
    end
  endtask : sweep

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    txv = 2'b00;
    txi = 2'b00;
    txp = 2'b00;
    rdy = 2'b11;
    txc = '{HVC_NOP, HVC_NOP};
    txt = '{8'h00, 8'h00};
    rst(1'b1);
    chk("mode", {14'h0000, mode}, 16'h0000);
    sweep();
    xf(0, HVC_RD, 1'b1, 1'b0, 8'h0A, 1'b1);
    xf(1, HVC_RD_REPLY, 1'b0, 1'b0, 8'h0A, 1'b1);
    // Forced pass flag lets a reply overtake a stalled write
    fppw <= 1'b1;
    byp <= 1'b1;
    // A read parks in the output stage so the write waits in its slot
    rdy[1] <= 1'b0;
    snd(0, HVC_RD, 1'b0, 1'b0, 8'h13);
    snd(0, HVC_WR_P, 1'b0, 1'b0, 8'h11);
    snd(0, HVC_TGT_DONE, 1'b0, 1'b0, 8'h12);
    repeat (8) @(posedge clk);
    rdy[1] <= 1'b1;
    rcv(1, HVC_RD, 1'b0, 1'b0, 8'h13);
    rcv(1, HVC_TGT_DONE, 1'b0, 1'b1, 8'h12);
    rcv(1, HVC_WR_P, 1'b0, 1'b0, 8'h11);
    fppw <= 1'b0;
    byp <= 1'b0;
    // Enable is ignored until a warm reset
    sw_en <= 1'b1;
    repeat (3) @(negedge clk);
    chk("mode", {14'h0000, mode}, 16'h0000);
    rst(1'b0);
    chk("mode", {14'h0000, mode}, 16'h0003);
    sweep();
    // Flagged broadcast holds the ordinary slot, high write still passes
    rdy[1] <= 1'b0;
    snd(0, HVC_RD, 1'b0, 1'b0, 8'h23);
    snd(0, HVC_BCAST, 1'b1, 1'b0, 8'h21);
    snd(0, HVC_WR_P, 1'b1, 1'b0, 8'h22);
    repeat (8) @(posedge clk);
    rdy[1] <= 1'b1;
    rcv(1, HVC_RD, 1'b0, 1'b0, 8'h23);
    rcv(1, HVC_WR_P, 1'b1, 1'b0, 8'h22);
    rcv(1, HVC_BCAST, 1'b1, 1'b0, 8'h21);
    sw_en <= 1'b0;
    rst(1'b1);
    chk("mode", {14'h0000, mode}, 16'h0000);
    finish_test();
  end
endmodule : tb_top
